// ---- include/msl_defs.svh ----
/*
 Constants of the motion input safety latch block: register offsets,
 field positions, reset values and timing counts.
 Assumes a 25 MHz core clock and a 5-bit word-address register port.
*/
// Operation
// [R1] Abort low halts all motion at once and ends the motion program
// [R2] Reset pin low resets processor, then restores saved state and parameters
// [R3] Active forward limit blocks forward motion of that axis
// [R4] Active reverse limit blocks reverse motion of that axis
// [R5] A newly active limit also starts the limit handler routine
// [R6] Limit and home polarity are selectable by the polarity command
// [R7] Homing or find-edge then begin: slew; home transition: decelerate
// [R8] General inputs are readable and raise an input interrupt event
// [R9] Armed latch captures axis position in under one microsecond
// [R10] Inputs 1-4 drive latches A-D, inputs 9-12 drive latches E-H
// [R11] Latch captures only when armed; otherwise input is ordinary
// [R12] Sign-magnitude strap picks step mode and rejects analog command
// [R13] Motor-off strap puts every axis in motor off on reset
// [R14] Factory restore strap restores defaults, only at power-on or reset
// [R15] Error light on when following error exceeds limit or hardware fails
// [R16] Activity light on while network data moves
// [R17] Error output low while any axis exceeds the error limit
// [R18] All switch and general inputs are synchronised before use
`ifndef MSL_DEFS_SVH
`define MSL_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define MSL_AW 5
`define MSL_A_GEN_IN 5'h00
`define MSL_A_SWITCH 5'h01
`define MSL_A_POLARITY 5'h02
`define MSL_A_HOMING 5'h03
`define MSL_A_FIND_EDGE 5'h04
`define MSL_A_BEGIN 5'h05
`define MSL_A_LATCH_ARM 5'h06
`define MSL_A_MOTOR_ON 5'h07
`define MSL_A_ERR_LIMIT 5'h08
`define MSL_A_INT_STATUS 5'h09
`define MSL_A_INT_MASK 5'h0a
`define MSL_A_ANALOG 5'h0b
`define MSL_A_STRAPS 5'h0c
`define MSL_A_LATCH_BASE 5'h10

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define MSL_POL_LIM 0
`define MSL_POL_HOME 1
`define MSL_POL_RST 2'h0
`define MSL_INT_W 6
`define MSL_ST_INPUT 0
`define MSL_ST_LIMIT 1
`define MSL_ST_ABORT 2
`define MSL_ST_LATCH 3
`define MSL_ST_HOME 4
`define MSL_ST_ANALOG 5
`define MSL_NLATCH 8
`define MSL_LATCH_LOW 4
`define MSL_LATCH_SKIP 4

// ****************************************************************
// Timing
// ****************************************************************
`define MSL_CLK_NS 40
`define MSL_LATCH_MAX_NS 1000
`define MSL_LATCH_MAX_CYC (`MSL_LATCH_MAX_NS / `MSL_CLK_NS)
`define MSL_BOOT_INIT 3'h7
`define MSL_BOOT_FIRE 3'h1

`endif

// ---- include/msl_pkg.sv ----
/*
 Types shared by the motion input safety latch block.
 Assumes msl_defs.svh supplies all numeric constants.
*/
`default_nettype none
package msl_pkg;
    typedef enum logic [2:0]
    {
        msl_h_idle = 3'h1,
        msl_h_armed = 3'h2,
        msl_h_slew = 3'h4
    } msl_home_t;
endpackage
`default_nettype wire

// ---- rtl/msl_sync.sv ----
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/1ps
`default_nettype none
module msl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } msl_sync_state_t;

    msl_sync_state_t st;
    msl_sync_state_t next_st;

    always_comb
    begin
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= {RST_VAL, RST_VAL};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule
`default_nettype wire

// ---- rtl/msl_latch.sv ----
/*
 One high-speed position latch: arm, catch a falling trigger, hold.
 Assumes trig is already synchronised and pos is on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module msl_latch #(
    parameter int POS_W = 32
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control and sources
    input wire logic arm,
    input wire logic trig,
    input wire logic [POS_W-1:0] pos,
    // Results
    output logic armed,
    output logic captured,
    output logic [POS_W-1:0] held
);
    typedef struct packed {
        logic prev;
        logic armed;
        logic captured;
        logic [POS_W-1:0] held;
    } msl_latch_state_t;

    msl_latch_state_t st;
    msl_latch_state_t next_st;
    logic fall;

    assign fall = st.prev && !trig;

    always_comb
    begin
        next_st = st;
        next_st.prev = trig;
        next_st.captured = 1'b0;
        if (st.armed && fall) // R9 R11
        begin
            next_st.held = pos;
            next_st.armed = 1'b0;
            next_st.captured = 1'b1;
        end
        // Re-arm in the capture cycle keeps the new request
        if (arm)
        begin
            next_st.armed = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '{prev: 1'b1, armed: 1'b0, captured: 1'b0, held: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign armed = st.armed;
    assign captured = st.captured;
    assign held = st.held;

    capture_on_edge_a: assert property ( // R9
        @(posedge core_clk) disable iff (rst)
        st.armed && fall |=> captured && held == $past(pos))
        else $error("armed latch missed its trigger");

    unarmed_hold_a: assert property ( // R11
        @(posedge core_clk) disable iff (rst)
        !st.armed |=> $stable(held))
        else $error("unarmed latch changed its position");
endmodule
`default_nettype wire

// ---- rtl/msl_top.sv ----
/*
 Input-side safety and latch logic of a multi-axis motion controller:
 abort, reset pin, limits, home, general inputs, position latches,
 jumper straps, error and activity lights, register port, interrupt.
 Assumes axis positions, following errors and network activity come
 from logic on core_clk; all pins and straps are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msl_defs.svh"
module msl_top #(
    parameter int NAXES = 8,
    parameter int NIN = 16,
    parameter int POS_W = 32
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [`MSL_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Switch and input pins
    input wire logic abort_n,
    input wire logic reset_n,
    input wire logic [NAXES-1:0] fwd_lim,
    input wire logic [NAXES-1:0] rev_lim,
    input wire logic [NAXES-1:0] home_sw,
    input wire logic [NIN-1:0] gen_in,
    // Jumper straps
    input wire logic [NAXES-1:0] sign_mag_select,
    input wire logic motor_off_on_reset,
    input wire logic factory_restore_select,
    // Motion core
    input wire logic [NAXES*POS_W-1:0] axis_pos,
    input wire logic [NAXES*POS_W-1:0] following_error_value,
    input wire logic hw_fault,
    input wire logic net_tx_busy,
    input wire logic net_rx_busy,
    // Motion control outputs
    output logic motion_halt,
    output logic prog_abort,
    output logic proc_reset,
    output logic state_restore,
    output logic factory_restore,
    output logic [NAXES-1:0] fwd_block,
    output logic [NAXES-1:0] rev_block,
    output logic limit_handler_routine,
    output logic [NAXES-1:0] slew_req,
    output logic [NAXES-1:0] decel_req,
    output logic [NAXES-1:0] step_mode,
    output logic [NAXES-1:0] analog_en,
    output logic [NAXES-1:0] motor_off,
    // Indicators and interrupt
    output logic error_n,
    output logic error_led,
    output logic activity_led,
    output logic irq
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    localparam int SW = 4 + 4*NAXES + NIN;

    function automatic logic wr_hit(input logic [`MSL_AW-1:0] off);
        return reg_wr && reg_addr == off;
    endfunction

    // Latch number to general input index
    function automatic int latch_src(input int i);
        return (i < `MSL_LATCH_LOW) ? i : i + `MSL_LATCH_SKIP;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0] boot;
        logic abort_q;
        logic rpin_q;
        logic [NAXES-1:0] fwd_q;
        logic [NAXES-1:0] rev_q;
        logic [NAXES-1:0] home_q;
        logic [NIN-1:0] gen_q;
        logic [1:0] pol;
        msl_pkg::msl_home_t [NAXES-1:0] home_st;
        logic [POS_W-1:0] err_limit;
        logic [`MSL_INT_W-1:0] int_status;
        logic [`MSL_INT_W-1:0] int_mask;
        logic [31:0] rdata;
        logic motion_halt;
        logic prog_abort;
        logic proc_reset;
        logic state_restore;
        logic factory_restore;
        logic [NAXES-1:0] fwd_block;
        logic [NAXES-1:0] rev_block;
        logic lim_handler;
        logic [NAXES-1:0] slew_req;
        logic [NAXES-1:0] decel_req;
        logic [NAXES-1:0] step_mode;
        logic [NAXES-1:0] analog_en;
        logic [NAXES-1:0] motor_off;
        logic error_n;
        logic error_led;
        logic activity_led;
        logic irq;
    } msl_state_t;

    msl_state_t st;
    msl_state_t next_st;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic [SW-1:0] sync_q;
    logic abort_s;
    logic reset_s;
    logic [NAXES-1:0] fwd_s;
    logic [NAXES-1:0] rev_s;
    logic [NAXES-1:0] home_s;
    logic [NIN-1:0] gen_s;
    logic [NAXES-1:0] sm_s;
    logic mo_s;
    logic factory_restore_select_s;

    // Idle-high reset keeps the first cycles free of false edges
    msl_sync #(.W(SW), .RST_VAL({SW{1'b1}})) u_sync ( // R18
        .core_clk(core_clk),
        .rst(rst),
        .async_in({factory_restore_select, motor_off_on_reset,
                   sign_mag_select, gen_in, home_sw, rev_lim, fwd_lim,
                   reset_n, abort_n}),
        .sync_out(sync_q)
    );

    assign abort_s = sync_q[0];
    assign reset_s = sync_q[1];
    assign fwd_s = sync_q[2 +: NAXES];
    assign rev_s = sync_q[2+NAXES +: NAXES];
    assign home_s = sync_q[2+2*NAXES +: NAXES];
    assign gen_s = sync_q[2+3*NAXES +: NIN];
    assign sm_s = sync_q[2+3*NAXES+NIN +: NAXES];
    assign mo_s = sync_q[2+4*NAXES+NIN];
    assign factory_restore_select_s = sync_q[3+4*NAXES+NIN];

    // ****************************************************************
    // Switch decoding
    // ****************************************************************
    logic [NAXES-1:0] fwd_act;
    logic [NAXES-1:0] rev_act;
    logic [NAXES-1:0] home_act;
    logic [NAXES-1:0] home_chg;
    logic lim_rise;
    logic reset_evt;
    logic exceeds;

    always_comb
    begin
        // Polarity bit set means active high, clear means active low
        fwd_act = st.pol[`MSL_POL_LIM] ? fwd_s : ~fwd_s; // R6
        rev_act = st.pol[`MSL_POL_LIM] ? rev_s : ~rev_s;
        home_act = st.pol[`MSL_POL_HOME] ? home_s : ~home_s;
        home_chg = home_act ^ st.home_q;
        lim_rise = |((fwd_act & ~st.fwd_q) | (rev_act & ~st.rev_q));
        // Straps are valid only once the synchroniser has filled
        reset_evt = (st.boot == `MSL_BOOT_FIRE) || (reset_s && !st.rpin_q);
        exceeds = 1'b0;
        for (int a = 0; a < NAXES; a++)
        begin
            if (following_error_value[a*POS_W +: POS_W] > st.err_limit)
            begin
                exceeds = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Position latches
    // ****************************************************************
    logic [`MSL_NLATCH-1:0] latch_armed;
    logic [`MSL_NLATCH-1:0] latch_cap;
    logic [POS_W-1:0] latch_held [`MSL_NLATCH];

    genvar gi;
    generate
        for (gi = 0; gi < `MSL_NLATCH; gi++)
        begin : g_latch
            msl_latch #(.POS_W(POS_W)) u_latch (
                .core_clk(core_clk),
                .rst(rst || !reset_s),
                .arm(wr_hit(`MSL_A_LATCH_ARM) && reg_wdata[gi]), // R11
                .trig(gen_s[latch_src(gi)]), // R10
                .pos(axis_pos[(gi % NAXES)*POS_W +: POS_W]),
                .armed(latch_armed[gi]),
                .captured(latch_cap[gi]),
                .held(latch_held[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic [`MSL_INT_W-1:0] int_set;
    logic [`MSL_INT_W-1:0] int_clr;
    logic [NAXES-1:0] an_req;

    always_comb
    begin
        next_st = st;
        int_set = '0;
        int_clr = '0;
        an_req = reg_wdata[NAXES-1:0];
        next_st.boot = st.boot >> 1;
        next_st.abort_q = abort_s;
        next_st.rpin_q = reset_s;
        next_st.fwd_q = fwd_act;
        next_st.rev_q = rev_act;
        next_st.home_q = home_act;
        next_st.gen_q = gen_s;
        next_st.prog_abort = 1'b0;
        next_st.state_restore = 1'b0;
        next_st.factory_restore = 1'b0;
        next_st.decel_req = '0;

        next_st.motion_halt = !abort_s; // R1
        if (!abort_s && st.abort_q)
        begin
            next_st.prog_abort = 1'b1; // R1
            int_set[`MSL_ST_ABORT] = 1'b1;
        end
        next_st.proc_reset = !reset_s; // R2
        // Motor-on write first, so a reset in the same cycle wins
        if (wr_hit(`MSL_A_MOTOR_ON))
        begin
            next_st.motor_off = st.motor_off & ~reg_wdata[NAXES-1:0];
        end
        if (reset_evt)
        begin
            // Strap is caught only here, so changes apply at reset
            if (factory_restore_select_s)
            begin
                next_st.factory_restore = 1'b1; // R14
            end
            else
            begin
                next_st.state_restore = 1'b1; // R2
            end
            if (mo_s)
            begin
                next_st.motor_off = '1; // R13
            end
        end

        next_st.fwd_block = fwd_act; // R3
        next_st.rev_block = rev_act; // R4
        next_st.lim_handler = lim_rise; // R5
        int_set[`MSL_ST_LIMIT] = lim_rise;
        int_set[`MSL_ST_INPUT] = |(gen_s ^ st.gen_q); // R8
        int_set[`MSL_ST_LATCH] = |latch_cap;

        for (int a = 0; a < NAXES; a++)
        begin
            case (st.home_st[a])
                msl_pkg::msl_h_idle:
                    if ((wr_hit(`MSL_A_HOMING) || wr_hit(`MSL_A_FIND_EDGE))
                        && reg_wdata[a])
                    begin
                        next_st.home_st[a] = msl_pkg::msl_h_armed;
                    end
                msl_pkg::msl_h_armed:
                    if (wr_hit(`MSL_A_BEGIN) && reg_wdata[a])
                    begin
                        next_st.home_st[a] = msl_pkg::msl_h_slew; // R7
                    end
                msl_pkg::msl_h_slew:
                    if (home_chg[a])
                    begin
                        next_st.home_st[a] = msl_pkg::msl_h_idle; // R7
                        next_st.decel_req[a] = 1'b1;
                        int_set[`MSL_ST_HOME] = 1'b1;
                    end
                default:
                    next_st.home_st[a] = msl_pkg::msl_h_idle;
            endcase
            // Abort and reset drop every pending home move
            if (!abort_s || !reset_s)
            begin
                next_st.home_st[a] = msl_pkg::msl_h_idle; // R1
            end
            next_st.slew_req[a] = next_st.home_st[a] == msl_pkg::msl_h_slew;
        end

        next_st.step_mode = sm_s; // R12
        if (wr_hit(`MSL_A_ANALOG))
        begin
            next_st.analog_en = an_req & ~sm_s; // R12
            int_set[`MSL_ST_ANALOG] = |(an_req & sm_s);
        end
        else
        begin
            next_st.analog_en = st.analog_en & ~sm_s;
        end

        if (wr_hit(`MSL_A_POLARITY))
        begin
            next_st.pol = reg_wdata[1:0]; // R6
        end
        if (wr_hit(`MSL_A_ERR_LIMIT))
        begin
            next_st.err_limit = reg_wdata[POS_W-1:0];
        end
        if (wr_hit(`MSL_A_INT_MASK))
        begin
            next_st.int_mask = reg_wdata[`MSL_INT_W-1:0];
        end
        if (wr_hit(`MSL_A_INT_STATUS))
        begin
            int_clr = reg_wdata[`MSL_INT_W-1:0];
        end
        // Set wins over a clear in the same cycle
        next_st.int_status = (st.int_status & ~int_clr) | int_set;
        next_st.irq = |(next_st.int_status & next_st.int_mask);

        next_st.error_n = !exceeds; // R17
        next_st.error_led = exceeds || hw_fault; // R15
        next_st.activity_led = net_tx_busy || net_rx_busy; // R16

        next_st.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                `MSL_A_GEN_IN: next_st.rdata = 32'(gen_s); // R8
                `MSL_A_SWITCH:
                    next_st.rdata = 32'({home_act, rev_act, fwd_act});
                `MSL_A_POLARITY: next_st.rdata = 32'(st.pol);
                `MSL_A_HOMING: next_st.rdata = 32'(st.slew_req);
                `MSL_A_LATCH_ARM: next_st.rdata = 32'(latch_armed);
                `MSL_A_MOTOR_ON: next_st.rdata = 32'(st.motor_off);
                `MSL_A_ERR_LIMIT: next_st.rdata = 32'(st.err_limit);
                `MSL_A_INT_STATUS: next_st.rdata = 32'(st.int_status);
                `MSL_A_INT_MASK: next_st.rdata = 32'(st.int_mask);
                `MSL_A_ANALOG: next_st.rdata = 32'(st.analog_en);
                `MSL_A_STRAPS:
                    next_st.rdata = 32'({factory_restore_select_s, mo_s, sm_s});
                default:
                    if (reg_addr >= `MSL_A_LATCH_BASE)
                    begin
                        next_st.rdata = 32'(latch_held[reg_addr[2:0]]);
                    end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.boot <= `MSL_BOOT_INIT;
            st.abort_q <= 1'b1;
            st.rpin_q <= 1'b1;
            st.gen_q <= '1;
            st.pol <= `MSL_POL_RST;
            for (int a = 0; a < NAXES; a++)
            begin
                st.home_st[a] <= msl_pkg::msl_h_idle;
            end
            st.err_limit <= '1;
            st.error_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = st.rdata;
    assign motion_halt = st.motion_halt;
    assign prog_abort = st.prog_abort;
    assign proc_reset = st.proc_reset;
    assign state_restore = st.state_restore;
    assign factory_restore = st.factory_restore;
    assign fwd_block = st.fwd_block;
    assign rev_block = st.rev_block;
    assign limit_handler_routine = st.lim_handler;
    assign slew_req = st.slew_req;
    assign decel_req = st.decel_req;
    assign step_mode = st.step_mode;
    assign analog_en = st.analog_en;
    assign motor_off = st.motor_off;
    assign error_n = st.error_n;
    assign error_led = st.error_led;
    assign activity_led = st.activity_led;
    assign irq = st.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    abort_halts_a: assert property ( // R1
        $fell(abort_s) |=> motion_halt && prog_abort ##1 slew_req == '0)
        else $error("abort did not halt motion");
    fwd_block_a: assert property ( // R3
        fwd_act[0] |=> fwd_block[0])
        else $error("forward limit did not block");
    rev_block_a: assert property ( // R4
        rev_act[0] |=> rev_block[0])
        else $error("reverse limit did not block");
    limit_handler_a: assert property ( // R5
        lim_rise |=> limit_handler_routine && st.int_status[`MSL_ST_LIMIT])
        else $error("limit handler not started");
    home_stop_a: assert property ( // R7
        slew_req[0] && home_chg[0] && abort_s && reset_s
        |=> decel_req[0] && !slew_req[0])
        else $error("home transition did not stop slew");
    input_event_a: assert property ( // R8
        gen_s != st.gen_q |=> st.int_status[`MSL_ST_INPUT])
        else $error("input change raised no event");
    analog_guard_a: assert property ( // R12
        ##1 (analog_en & step_mode) == '0)
        else $error("analog enabled on a step axis");
    motor_off_a: assert property ( // R13
        reset_evt && mo_s |=> motor_off == '1)
        else $error("reset left a motor on");
    error_out_a: assert property ( // R17
        exceeds |=> !error_n && error_led)
        else $error("error output missed an overrun");
    activity_a: assert property ( // R16
        (net_tx_busy || net_rx_busy) != activity_led |=> $changed(activity_led))
        else $error("activity light out of step");
endmodule
`default_nettype wire

// ---- dv/msl_pins_model.sv ----
/*
 Far-side model: abort, reset, limit, home and general input pins.
 Assumes the bench calls put just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module msl_pins_model
(
    // Pins
    output logic abort_n,
    output logic reset_n,
    output logic [7:0] fwd_lim,
    output logic [7:0] rev_lim,
    output logic [7:0] home_sw,
    output logic [15:0] gen_in
);
    // Idle pins read high, as with pull-ups
    initial
    begin
        abort_n = 1'b1;
        reset_n = 1'b1;
        fwd_lim = 8'hff;
        rev_lim = 8'hff;
        home_sw = 8'hff;
        gen_in = 16'hffff;
    end
    task put(input int k, input int i, input logic v);
        case (k)
            0: abort_n <= v;
            1: fwd_lim[i] <= v;
            2: rev_lim[i] <= v;
            3: gen_in[i] <= v;
            5: reset_n <= v;
            default: home_sw[i] <= v;
        endcase
    endtask
endmodule
`default_nettype wire

// ---- dv/motion_input_safety_latch_tb_top.sv ----
/*
 Self-checking bench of msl_top with the pin model.
 Assumes reads answer one cycle after the read edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msl_defs.svh"
module motion_input_safety_latch_tb_top;
    logic core_clk, rst, reg_wr, reg_rd, rd_seen;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed;
    logic abort_n, reset_n, hw_fault, net_tx_busy, net_rx_busy;
    logic [7:0] fwd_lim, rev_lim, home_sw, sign_mag_select;
    logic [15:0] gen_in;
    logic motor_off_on_reset, factory_restore_select;
    logic [255:0] axis_pos, following_error_value;
    logic motion_halt, prog_abort, proc_reset, state_restore;
    logic factory_restore, limit_handler_routine, irq;
    logic error_n, error_led, activity_led;
    logic [7:0] fwd_block, rev_block, slew_req, decel_req;
    logic [7:0] step_mode, analog_en, motor_off;
    logic [31:0] q[$];
    int n_errors = 0;
    int tests_run = 0;
    msl_top dut (.*);
    msl_pins_model pins (.*);
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge core_clk);
        q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task close_out;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data lives only in the cycle after the read edge
    always @(posedge core_clk)
        rd_seen <= reg_rd;
    always @(negedge core_clk)
        if (rd_seen)
            chk(reg_rdata, q.pop_front());
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        #400000;
        n_errors++;
        close_out;
    end
    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {hw_fault, net_tx_busy, net_rx_busy, sign_mag_select} = '0;
        {motor_off_on_reset, factory_restore_select} = '0;
        following_error_value = '0;
        seed = 32'h796a;
        for (int i = 0; i < 8; i++)
            axis_pos[i*32+:32] = xs();
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(`MSL_A_POLARITY, 32'h0);
        rd(`MSL_A_ERR_LIMIT, 32'hffffffff);
        sign_mag_select <= 8'h05;
        settle(4);
        chk(step_mode, 8'h05);
        wr(`MSL_A_ANALOG, 32'hff);
        rd(`MSL_A_ANALOG, 32'hfa);
        pins.put(1, 3, 1'b0);
        pins.put(2, 5, 1'b0);
        settle(4);
        chk(fwd_block, 8'h08);
        chk(rev_block, 8'h20);
        rd(`MSL_A_INT_STATUS, 32'h22);
        wr(`MSL_A_POLARITY, 32'h1);
        settle(3);
        chk(fwd_block, 8'hf7);
        wr(`MSL_A_POLARITY, 32'h0);
        pins.put(1, 3, 1'b1);
        pins.put(2, 5, 1'b1);
        wr(`MSL_A_INT_STATUS, 32'h3f);
        wr(`MSL_A_INT_MASK, 32'h4);
        pins.put(0, 0, 1'b0);
        settle(1);
        chk(motion_halt, 1'b0);
        settle(3);
        chk(motion_halt, 1'b1);
        chk(irq, 1'b1);
        pins.put(0, 0, 1'b1);
        wr(`MSL_A_INT_STATUS, 32'h4);
        settle(4);
        chk({motion_halt, irq}, 2'b00);
        for (int i = 0; i < 2; i++)
        begin
            pins.put(3, i * 8, 1'b0);
            settle(4);
            rd(`MSL_A_LATCH_BASE + 5'(i * 4), 32'h0);
            pins.put(3, i * 8, 1'b1);
            settle(4);
            wr(`MSL_A_LATCH_ARM, 32'h1 << (i * 4));
            pins.put(3, i * 8, 1'b0);
            settle(6);
            rd(`MSL_A_LATCH_BASE + 5'(i * 4), axis_pos[i*128+:32]);
            pins.put(3, i * 8, 1'b1);
        end
        settle(4);
        rd(`MSL_A_GEN_IN, 32'hffff);
        wr(`MSL_A_HOMING, 32'h1);
        wr(`MSL_A_BEGIN, 32'h1);
        rd(`MSL_A_HOMING, 32'h1);
        pins.put(4, 0, 1'b0);
        settle(5);
        rd(`MSL_A_HOMING, 32'h0);
        wr(`MSL_A_ERR_LIMIT, 32'hf);
        following_error_value[63:32] <= 32'h10;
        settle(3);
        chk({error_n, error_led}, 2'b01);
        @(posedge core_clk);
        following_error_value[63:32] <= 32'h0;
        hw_fault <= 1'b1;
        net_rx_busy <= 1'b1;
        settle(3);
        chk({error_led, activity_led}, 2'b11);
        @(posedge core_clk);
        {motor_off_on_reset, factory_restore_select} <= 2'b11;
        pins.put(5, 0, 1'b0);
        settle(4);
        chk(proc_reset, 1'b1);
        rd(`MSL_A_LATCH_BASE, 32'h0);
        pins.put(5, 0, 1'b1);
        settle(3);
        chk({factory_restore, state_restore, motor_off}, 10'h2ff);
        settle(2);
        close_out;
    end
endmodule
`default_nettype wire
